// ===== cpu_pkg.sv
package cpu_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PC_W = 10;
  localparam int INSTR_W = 18;
  localparam int REG_CNT = 16;
  localparam int SPAD_DEPTH = 64;
  localparam int STACK_DEPTH = 31;
  localparam int AXI_AW = 12;

  // ----------------------------------------------------------------
  // Fixed addresses and register map
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] IRQ_VECTOR = 10'h3FF;
  localparam logic [AXI_AW-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [AXI_AW-1:0] STATUS_OFFSET = 12'h004;
  localparam logic [AXI_AW-1:0] SPAD_BASE = 12'h100;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_PC_LSB = 0;
  localparam int STAT_ZERO_BIT = 10;
  localparam int STAT_CARRY_BIT = 11;
  localparam int STAT_IE_BIT = 12;
  localparam int STAT_PZERO_BIT = 13;
  localparam int STAT_PCARRY_BIT = 14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Instruction word fields
  // ----------------------------------------------------------------
  localparam int OP_LSB = 12;
  localparam int DEST_LSB = 8;
  localparam int SRC_LSB = 4;
  localparam int COND_LSB = 10;

  typedef enum logic [5:0] {
    OP_ADD_K = 6'h00,
    OP_ADD_R = 6'h01,
    OP_ADDC_K = 6'h02,
    OP_ADDC_R = 6'h03,
    OP_AND_K = 6'h04,
    OP_AND_R = 6'h05,
    OP_CMP_K = 6'h06,
    OP_CMP_R = 6'h07,
    OP_CALL = 6'h08,
    OP_CALL_CC = 6'h09,
    OP_JUMP = 6'h0A,
    OP_JUMP_CC = 6'h0B,
    OP_IRQ_EN = 6'h0C,
    OP_IRQ_DIS = 6'h0D,
    OP_FETCH_R = 6'h0E,
    OP_FETCH_K = 6'h0F,
    OP_IN_R = 6'h10,
    OP_IN_K = 6'h11
  } op_t;

  typedef enum logic [1:0] {
    CC_Z = 2'h0,
    CC_NZ = 2'h1,
    CC_C = 2'h2,
    CC_NC = 2'h3
  } cond_t;

  typedef enum logic [1:0] {
    ST_FETCH = 2'h0,
    ST_EXEC = 2'h1,
    ST_INPUT = 2'h3,
    ST_IRQ = 2'h2
  } state_t;

endpackage : cpu_pkg

// ===== reg_bank.sv
`timescale 1ns/10ps
module reg_bank
  import cpu_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = REG_CNT
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_a_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_b_i,
  output logic [WIDTH-1:0] rdata_a_o,
  output logic [WIDTH-1:0] rdata_b_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];

  if (DEPTH < 2 || WIDTH < 1)
  begin : g_bad_size
    $error("reg_bank size not supported");
  end

  // ----------------------------------------------------------------
  // One flip-flop row per entry
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_row
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        mem_r[i] <= '0;
      else if (ce_i && we_i && waddr_i == AW'(i))
        mem_r[i] <= wdata_i;
    end
  end

  assign rdata_a_o = mem_r[raddr_a_i];
  assign rdata_b_o = mem_r[raddr_b_i];

endmodule : reg_bank

// ===== cpu_core.sv
`timescale 1ns/10ps
// How it works
// - ADD immediate stores the sum in dest_reg and updates zero and carry
// - ADD register stores the sum in dest_reg and updates zero and carry
// - add_with_carry adds the carry flag too, stores, updates zero and carry
// - AND stores the result, zero from result, carry forced to 0
// - Unconditional call pushes program_counter then loads the target
// - Carry calls push and branch only on carry set or clear
// - Zero calls push and branch only on zero set or clear
// - Compare keeps registers, zero when equal, carry when dest is lower
// - irq_enable_instr sets, irq_disable_instr clears accept flag, flags untouched
// - Interrupt saves flags, clears accept flag, pushes counter, jumps to 3FF
// - Indirect fetch loads scratchpad at src_reg value, flags untouched
// - Direct fetch loads scratchpad at constant address, flags untouched
// - Indirect input drives src_reg as port address, captures input bus
// - Direct input drives port_const as port address, captures input bus
// - Unconditional jump loads target and pushes nothing
// - Conditional jumps load target only when the condition holds
// - Calls, jumps, fetches, inputs, interrupt control leave flags alone
// - With accept flag clear the interrupt input is ignored
// - Input takes three cycles, read strobe on the third
module cpu_core
  import cpu_pkg::*;
#(
  parameter int STACK_N = STACK_DEPTH,
  parameter int SPAD_N = SPAD_DEPTH
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [INSTR_W-1:0] instr_i,
  output logic [PC_W-1:0] instr_addr_o,
  input wire logic [DATA_W-1:0] in_port_i,
  output logic [DATA_W-1:0] io_port_address_o,
  output logic read_strobe_o,
  input wire logic irq_i,
  output logic irq_ack_o,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int SP_W = $clog2(SPAD_N);
  localparam int STK_W = $clog2(STACK_N + 1);

  if (STACK_N < 1 || SPAD_N < 2 || SPAD_N > 256)
  begin : g_bad_size
    $error("cpu_core size not supported");
  end

  state_t state_r;
  logic [PC_W-1:0] program_counter_r;
  logic zero_r;
  logic carry_r;
  logic pzero_r;
  logic pcarry_r;
  logic irq_en_r;
  logic [PC_W-1:0] call_stack_r [STACK_N];
  logic [STK_W-1:0] sp_r;
  logic [DATA_W-1:0] spad_r [SPAD_N];
  logic [DATA_W-1:0] port_addr_r;
  logic read_strobe_r;
  logic irq_ack_r;
  logic [31:0] ctrl_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  op_t op;
  cond_t cond;
  logic [3:0] dest_sel;
  logic [3:0] src_sel;
  logic [DATA_W-1:0] imm_byte;
  logic [PC_W-1:0] target;
  logic [DATA_W-1:0] dest_reg;
  logic [DATA_W-1:0] src_reg;
  logic [DATA_W-1:0] operand;
  logic [DATA_W:0] sum;
  logic cond_ok;
  logic stack_full;
  logic [DATA_W-1:0] spad_data;
  logic reg_we;
  logic [DATA_W-1:0] reg_wdata;
  logic irq_take;
  logic run;

  assign op = op_t'(instr_i[INSTR_W-1:OP_LSB]);
  assign cond = cond_t'(instr_i[COND_LSB+1:COND_LSB]);
  assign dest_sel = instr_i[DEST_LSB+3:DEST_LSB];
  assign src_sel = instr_i[SRC_LSB+3:SRC_LSB];
  assign imm_byte = instr_i[DATA_W-1:0];
  assign target = instr_i[PC_W-1:0];
  assign operand = instr_i[OP_LSB] ? src_reg : imm_byte;
  assign sum = {1'b0, dest_reg} + {1'b0, operand} +
               {{DATA_W{1'b0}}, (op == OP_ADDC_K || op == OP_ADDC_R) && carry_r};
  assign stack_full = (sp_r == STK_W'(STACK_N));
  assign run = ctrl_r[CTRL_RUN_BIT];
  assign irq_take = irq_en_r && irq_i;

  always_comb
  begin
    case (cond)
      CC_Z: cond_ok = zero_r;
      CC_NZ: cond_ok = !zero_r;
      CC_C: cond_ok = carry_r;
      CC_NC: cond_ok = !carry_r;
      default: cond_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    if (op == OP_FETCH_R)
      spad_data = spad_r[src_reg[SP_W-1:0]];
    else
      spad_data = spad_r[imm_byte[SP_W-1:0]];
  end

  // ----------------------------------------------------------------
  // Register bank write selection
  // ----------------------------------------------------------------
  always_comb
  begin
    reg_we = 1'b0;
    reg_wdata = sum[DATA_W-1:0];
    if (state_r == ST_INPUT)
    begin
      reg_we = 1'b1;
      reg_wdata = in_port_i;
    end
    else if (state_r == ST_EXEC)
    begin
      case (op)
        OP_ADD_K, OP_ADD_R, OP_ADDC_K, OP_ADDC_R:
          reg_we = 1'b1;
        OP_AND_K, OP_AND_R:
        begin
          reg_we = 1'b1;
          reg_wdata = dest_reg & operand;
        end
        OP_FETCH_R, OP_FETCH_K:
        begin
          reg_we = 1'b1;
          reg_wdata = spad_data;
        end
        default: reg_we = 1'b0;
      endcase
    end
  end

  reg_bank #(
    .WIDTH(DATA_W),
    .DEPTH(REG_CNT)
  ) u_regs (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .we_i(reg_we),
    .waddr_i(dest_sel),
    .wdata_i(reg_wdata),
    .raddr_a_i(dest_sel),
    .raddr_b_i(src_sel),
    .rdata_a_o(dest_reg),
    .rdata_b_o(src_reg)
  );

  // ----------------------------------------------------------------
  // Sequencer and program counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= ST_FETCH;
      program_counter_r <= '0;
    end
    else if (ce_i)
    begin
      case (state_r)
        ST_FETCH:
          if (irq_take)
          begin
            state_r <= ST_IRQ;
            program_counter_r <= IRQ_VECTOR;
          end
          else if (run)
            state_r <= ST_EXEC;
        ST_EXEC:
        begin
          state_r <= ST_FETCH;
          case (op)
            OP_CALL, OP_JUMP:
              program_counter_r <= target;
            OP_CALL_CC, OP_JUMP_CC:
              program_counter_r <= cond_ok ? target : program_counter_r + 1'b1;
            OP_IN_R, OP_IN_K:
              state_r <= ST_INPUT;
            default:
              program_counter_r <= program_counter_r + 1'b1;
          endcase
        end
        ST_INPUT:
        begin
          state_r <= ST_FETCH;
          program_counter_r <= program_counter_r + 1'b1;
        end
        ST_IRQ: state_r <= ST_FETCH;
        default: state_r <= ST_FETCH;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Zero and carry flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      zero_r <= 1'b0;
      carry_r <= 1'b0;
    end
    else if (ce_i && state_r == ST_EXEC)
    begin
      case (op)
        OP_ADD_K, OP_ADD_R, OP_ADDC_K, OP_ADDC_R:
        begin
          zero_r <= (sum[DATA_W-1:0] == '0);
          carry_r <= sum[DATA_W];
        end
        OP_AND_K, OP_AND_R:
        begin
          zero_r <= ((dest_reg & operand) == '0);
          carry_r <= 1'b0;
        end
        OP_CMP_K, OP_CMP_R:
        begin
          zero_r <= (dest_reg == operand);
          carry_r <= (dest_reg < operand);
        end
        default:
        begin
          zero_r <= zero_r;
          carry_r <= carry_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt accept flag and preserved flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_en_r <= 1'b0;
      pzero_r <= 1'b0;
      pcarry_r <= 1'b0;
      irq_ack_r <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_ack_r <= (state_r == ST_FETCH) && irq_take;
      if (state_r == ST_FETCH && irq_take)
      begin
        pzero_r <= zero_r;
        pcarry_r <= carry_r;
        irq_en_r <= 1'b0;
      end
      else if (state_r == ST_EXEC && op == OP_IRQ_EN)
        irq_en_r <= 1'b1;
      else if (state_r == ST_EXEC && op == OP_IRQ_DIS)
        irq_en_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Call stack
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      sp_r <= '0;
    else if (ce_i)
    begin
      if ((state_r == ST_FETCH && irq_take) ||
          (state_r == ST_EXEC && (op == OP_CALL || (op == OP_CALL_CC && cond_ok))))
      begin
        call_stack_r[stack_full ? STK_W'(0) : sp_r] <= program_counter_r;
        sp_r <= stack_full ? STK_W'(1) : sp_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port address and read strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      port_addr_r <= '0;
      read_strobe_r <= 1'b0;
    end
    else if (ce_i)
    begin
      read_strobe_r <= (state_r == ST_EXEC) && (op == OP_IN_R || op == OP_IN_K);
      if (state_r == ST_EXEC && op == OP_IN_R)
        port_addr_r <= src_reg;
      else if (state_r == ST_EXEC && op == OP_IN_K)
        port_addr_r <= imm_byte;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel, control and scratchpad
  // ----------------------------------------------------------------
  logic wr_fire;
  logic wr_spad;
  assign wr_fire = !awready_r && !wready_r && !bvalid_r;
  assign wr_spad = (awaddr_r >= SPAD_BASE) &&
                   (awaddr_r < SPAD_BASE + AXI_AW'(SPAD_N * 4));

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      ctrl_r <= CTRL_RESET;
    end
    else if (ce_i)
    begin
      if (awready_r && s_axi_awvalid)
      begin
        awready_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (wready_r && s_axi_wvalid)
      begin
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= (awaddr_r == CTRL_OFFSET || wr_spad) ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_r == CTRL_OFFSET && wstrb_r[0])
          ctrl_r[7:0] <= wdata_r[7:0];
        if (wr_spad && wstrb_r[0])
          spad_r[awaddr_r[SP_W+1:2]] <= wdata_r[DATA_W-1:0];
      end
      if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel, status and scratchpad
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (arready_r && s_axi_arvalid)
      begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rresp_r <= RESP_OKAY;
        rdata_r <= '0;
        if (s_axi_araddr == CTRL_OFFSET)
          rdata_r <= ctrl_r;
        else if (s_axi_araddr == STATUS_OFFSET)
        begin
          rdata_r[STAT_PC_LSB+PC_W-1:STAT_PC_LSB] <= program_counter_r;
          rdata_r[STAT_ZERO_BIT] <= zero_r;
          rdata_r[STAT_CARRY_BIT] <= carry_r;
          rdata_r[STAT_IE_BIT] <= irq_en_r;
          rdata_r[STAT_PZERO_BIT] <= pzero_r;
          rdata_r[STAT_PCARRY_BIT] <= pcarry_r;
        end
        else if (s_axi_araddr >= SPAD_BASE &&
                 s_axi_araddr < SPAD_BASE + AXI_AW'(SPAD_N * 4))
          rdata_r[DATA_W-1:0] <= spad_r[s_axi_araddr[SP_W+1:2]];
        else
          rresp_r <= RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
      begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign instr_addr_o = program_counter_r;
  assign io_port_address_o = port_addr_r;
  assign read_strobe_o = read_strobe_r;
  assign irq_ack_o = irq_ack_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule : cpu_core

// ===== cpu_core_monitor.sv
`timescale 1ns/10ps
module cpu_core_monitor
  import cpu_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic [PC_W-1:0] instr_addr_o,
  input wire logic [DATA_W-1:0] io_port_address_o,
  input wire logic read_strobe_o,
  input wire logic irq_i,
  input wire logic irq_ack_o,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ------------------------------
  // Input and interrupt checks
  // ------------------------------
  strobe_pulse_a:
    assert property (read_strobe_o |=> !read_strobe_o) else $error("read strobe too long");
  strobe_cause_a:
    assert property ($rose(read_strobe_o) |-> $past(instr_i[17:13]) == 5'h08)
      else $error("read strobe without input");
  port_direct_a:
    assert property ($rose(read_strobe_o) && $past(instr_i[17:12]) == OP_IN_K
      |-> io_port_address_o == $past(instr_i[7:0])) else $error("wrong direct port");
  port_hold_a:
    assert property (read_strobe_o |=> $stable(io_port_address_o)) else $error("port moved");
  ack_pulse_a:
    assert property (irq_ack_o |=> !irq_ack_o) else $error("ack too long");
  ack_vector_a:
    assert property (irq_ack_o |-> instr_addr_o == IRQ_VECTOR) else $error("not at vector");
  ack_cause_a:
    assert property ($rose(irq_ack_o) |-> $past(irq_i)) else $error("ack without request");
  // ------------------------------
  // Register bus checks
  // ------------------------------
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  rd_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
  wr_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  cover property ($rose(read_strobe_o));
  cover property ($rose(irq_ack_o));
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : cpu_core_monitor

// ===== fabric_model.sv
`timescale 1ns/10ps
module fabric_model
  import cpu_pkg::*;
(
  input wire logic clk_i,
  input wire logic [DATA_W-1:0] io_port_address_i,
  input wire logic read_strobe_i,
  output logic [DATA_W-1:0] in_port_o
);
  logic [DATA_W-1:0] noise_r = 8'h00;
  // ------------------------------
  // Port data, valid only under strobe
  // ------------------------------
  always_ff @(posedge clk_i)
    noise_r <= noise_r + 8'h3B;
  assign in_port_o = read_strobe_i ? (io_port_address_i ^ 8'hA5) : ~noise_r;
endmodule : fabric_model

// ===== byte_cpu_instr_exec_a_to_j_tb.sv
`timescale 1ns/10ps
module byte_cpu_instr_exec_a_to_j_tb
  import cpu_pkg::*;
;
  logic clk_i, rst_b_i, ce_i, irq_i, read_strobe_o, irq_ack_o;
  logic [INSTR_W-1:0] instr_i;
  logic [PC_W-1:0] instr_addr_o;
  logic [DATA_W-1:0] in_port_i, io_port_address_o;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [INSTR_W-1:0] rom [1024];
  logic [7:0] sp [SPAD_DEPTH];
  logic [7:0] m_r [REG_CNT];
  logic [7:0] exp_q [$];
  logic m_z, m_c;
  logic [5:0] ops [11] = '{OP_ADD_K, OP_ADD_R, OP_ADDC_K, OP_ADDC_R, OP_AND_K, OP_AND_R,
    OP_CMP_K, OP_CMP_R, OP_FETCH_R, OP_FETCH_K, OP_IN_K};
  logic [5:0] brs [4] = '{OP_JUMP_CC, OP_CALL_CC, OP_JUMP, OP_CALL};
  int seed = 32'h7294;
  int bad_count, samples_checked, ack_cnt, pc_e, a;

  cpu_core dut (.*);
  fabric_model fab_u (.clk_i(clk_i), .io_port_address_i(io_port_address_o),
    .read_strobe_i(read_strobe_o), .in_port_o(in_port_i));

  // ------------------------------
  // Clock, program store, probes
  // ------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    instr_i <= rom[instr_addr_o];
    if (irq_ack_o === 1'b1) ack_cnt++;
    if (read_strobe_o === 1'b1)
      check(io_port_address_o, exp_q.size() > 0 ? exp_q.pop_front() : 32'h1FF);
  end

  // ------------------------------
  // Tasks and functions
  // ------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task axi_wr(input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    if (n == 100) bad_count++;
    if (n == 100) end_sim;
  endtask : axi_wr
  task axi_rd(input logic [11:0] ad);
    int n;
    @(posedge clk_i);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    if (n == 100) bad_count++;
    if (n == 100) end_sim;
  endtask : axi_rd
  task wait_pc(input logic [9:0] p);
    int n;
    for (n = 0; n < 20000 && instr_addr_o !== p; n++)
      @(posedge clk_i);
    if (n == 20000) bad_count++;
    if (n == 20000) end_sim;
  endtask : wait_pc
  task emit(input logic [17:0] w);
    rom[pc_e] = w;
    pc_e++;
  endtask : emit
  function logic [7:0] exp_in(input logic [7:0] p);
    return p ^ 8'hA5;
  endfunction : exp_in
  function logic cond_ok(input logic [1:0] c);
    return c == CC_Z ? m_z : c == CC_NZ ? !m_z : c == CC_C ? m_c : !m_c;
  endfunction : cond_ok
  // One random operation, a register probe and a branch probe
  task gen_step;
    logic [31:0] r;
    logic [5:0] op, br;
    logic [3:0] d, s;
    logic [7:0] k, b, res;
    logic [8:0] sum;
    logic [1:0] cn;
    r = $random(seed);
    op = ops[r[31:28] % 11];
    d = 4'd1 + 4'(r[7:0] % 14);
    s = 4'd1 + 4'(r[15:8] % 14);
    k = r[23:16];
    b = op[0] ? m_r[s] : k;
    res = m_r[d];
    if (op <= OP_CMP_R)
    begin
      emit({op, d, op[0] ? {s, 4'h0} : k});
      sum = m_r[d] + b + (op[2:1] == 2'h1 ? m_c : 1'b0);
      case (op[2:1])
        2'h3: {m_z, m_c} = {m_r[d] == b, m_r[d] < b};
        2'h2: {res, m_c} = {m_r[d] & b, 1'b0};
        default: {m_c, res} = sum;
      endcase
      if (op[2:1] != 2'h3) m_z = (res == 8'h00);
    end
    else if (op == OP_IN_K)
    begin
      emit({op, d, k});
      exp_q.push_back(k);
      res = exp_in(k);
    end
    else
    begin
      emit({op, d, op[0] ? k : {s, 4'h0}});
      res = sp[op[0] ? k[5:0] : m_r[s][5:0]];
    end
    m_r[d] = res;
    emit({OP_IN_R, 4'hF, d, 4'h0});
    exp_q.push_back(res);
    br = brs[r[27:26]];
    cn = br[0] ? r[25:24] : 2'h0;
    emit({br, cn, 10'(pc_e + 2)});
    if (br[0] && !cond_ok(cn)) exp_q.push_back({6'h38, cn});
    emit({OP_IN_K, 4'hF, 6'h38, cn});
  endtask : gen_step

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    {rst_b_i, irq_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    ce_i = 1'b1;
    for (int i = 0; i < 1024; i++) rom[i] = 18'h3F000;
    for (int i = 0; i < SPAD_DEPTH; i++) sp[i] = 8'($random(seed));
    for (int i = 0; i < REG_CNT; i++) m_r[i] = 8'h00;
    {m_z, m_c, pc_e} = '0;
    emit({OP_JUMP, 2'h0, 10'h000});
    pc_e = 2;
    repeat (60) gen_step;
    a = pc_e;
    emit({OP_IRQ_DIS, 12'h000});
    emit({OP_JUMP, 2'h0, 10'(a + 1)});
    rom[IRQ_VECTOR] = {OP_JUMP, 2'h0, IRQ_VECTOR};
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    axi_wr(CTRL_OFFSET, 32'h0);
    axi_rd(CTRL_OFFSET);
    check(rd, 32'h0);
    for (int i = 0; i < SPAD_DEPTH; i++) axi_wr(SPAD_BASE + 12'(4 * i), {24'h0, sp[i]});
    for (int i = 0; i < SPAD_DEPTH; i += 7) axi_rd(SPAD_BASE + 12'(4 * i));
    check(rd[7:0], sp[63]);
    axi_wr(12'hFF0, 32'h1);
    check(rsp, RESP_SLVERR);
    axi_rd(12'hFF0);
    check(rsp, RESP_SLVERR);
    check(rd, 32'h0);
    rom[0] = {OP_JUMP, 2'h0, 10'h002};
    axi_wr(CTRL_OFFSET, 32'h1);
    wait_pc(10'(a + 1));
    check(exp_q.size(), 0);
    irq_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    irq_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(ack_cnt, 0);
    axi_rd(STATUS_OFFSET);
    check(rd[14:10], {3'h0, m_c, m_z});
    rom[a + 2] = {OP_IRQ_EN, 12'h000};
    rom[a + 3] = {OP_JUMP, 2'h0, 10'(a + 3)};
    rom[a + 1] = {OP_JUMP, 2'h0, 10'(a + 2)};
    wait_pc(10'(a + 3));
    axi_rd(STATUS_OFFSET);
    check(rd[14:0], {3'h1, m_c, m_z, 10'(a + 3)});
    ce_i <= 1'b0;
    irq_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    {ce_i, irq_i} <= 2'b10;
    repeat (3) @(posedge clk_i);
    check(ack_cnt, 0);
    irq_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    irq_i <= 1'b0;
    wait_pc(IRQ_VECTOR);
    repeat (4) @(posedge clk_i);
    check(ack_cnt, 1);
    axi_rd(STATUS_OFFSET);
    check(rd[14:0], {m_c, m_z, 1'b0, m_c, m_z, IRQ_VECTOR});
    end_sim;
  end
endmodule : byte_cpu_instr_exec_a_to_j_tb

bind cpu_core cpu_core_monitor mon (.*);
